// >>> fan_table_pkg.sv
// package: offsets, reset values, field layouts and carriers for the upper fan setpoint entries
package fan_table_pkg;

	localparam logic [7:0] ENTRY11_TEMP_LIMIT_OFS = 8'h64;
	localparam logic [7:0] ENTRY11_DUTY_OFS       = 8'h65;
	localparam logic [7:0] ENTRY12_TEMP_LIMIT_OFS = 8'h66;
	localparam logic [7:0] ENTRY12_DUTY_OFS       = 8'h67;
	localparam logic [7:0] TABLE_CTRL_OFS         = 8'h68;
	localparam logic [7:0] TABLE_STATUS_OFS       = 8'h69;

	localparam logic [7:0] TEMP_LIMIT_RESET = 8'h7f;
	localparam logic [7:0] DUTY_RESET       = 8'h3f;
	localparam logic [7:0] CTRL_RESET       = 8'h00;

	// temperature limit layout
	localparam int LIMIT_HALF_BIT = 7;
	localparam int LIMIT_WHOLE_HI = 6;
	// duty layout
	localparam int DUTY_EXT_LO  = 6;
	localparam int DUTY_BASE_HI = 5;

	// control register bit positions
	localparam int CTRL_WRITE_EN_BIT  = 0;
	localparam int CTRL_TEMP_HIRES    = 1;
	localparam int CTRL_DUTY_HIRES    = 2;
	localparam int CTRL_FREQ_22K5_BIT = 3;

	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic       write_en;
		logic       temp_hires;
		logic       duty_hires;
		logic       freq_22k5;
	} table_mode_t;

endpackage

// >>> fan_lut_upper_entries.sv
// fan setpoint table, entries 11 and 12: limit registers, duty registers and duty selection

//////////////////////////////////////////////////////////////////////////////
// Operation
// - In low temperature resolution the limit register's top bit reads as zero and plays no part.
// - In high temperature resolution the limit is the top bit with the lower seven bits.
// - In high resolution the limit spans 0 to 127.5 degrees in half-degree steps.
// - In low resolution the limit spans 0 to 127 degrees in whole-degree steps.
// - Above the entry 11 limit and not above the entry 12 limit the output duty is the value at offset 0x65.
// - Above the entry 12 limit at offset 0x66 the output duty is the value at offset 0x67.
// - The comparison uses nine temperature bits in high resolution and eight in low resolution.
// - Limits are positive only; the sign of a limit is always taken as zero.
// - Limits beyond the direct range come only from adding the external table offset.
// - In low duty resolution the duty register's top two bits read as zero.
// - In high duty resolution the top two bits join the lower six to form an eight-bit duty.
// - The extended duty bits act only while the 22.5 kHz frequency is selected.
// - In low duty resolution the duty comes from the lower six bits alone.
module fan_lut_upper_entries #(
	parameter int TEMP_W = 9
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     reset,
	// register port
	input  wire logic [7:0]               addr,
	input  wire logic [7:0]               wdata,
	input  wire logic                     wr,
	input  wire logic                     rd,
	output logic      [7:0]               rdata,
	// remote temperature, unsigned, lsb half a degree, and table offset in whole degrees
	input  wire logic [TEMP_W-1:0]        remote_temp,
	input  wire logic [7:0]               table_temp_offset,
	// duty result towards the pwm stage
	output logic      [7:0]               duty_out,
	output logic                          duty_valid
);

	// the compare paths below fix the reading at eight whole bits and one half bit
	if (TEMP_W != 9) begin : g_width_check
		$error("remote_temp must be 9 bits: 8 whole plus one half bit");
	end

	fan_table_pkg::reg_req_t    req;
	fan_table_pkg::table_mode_t mode;

	logic [7:0] e11_limit_r;
	logic [7:0] e11_duty_r;
	logic [7:0] e12_limit_r;
	logic [7:0] e12_duty_r;
	logic [3:0] ctrl_r;
	logic [7:0] rdata_nxt;
	logic [7:0] duty_nxt;
	logic       valid_nxt;
	logic [7:0] e11_limit_rd;
	logic [7:0] e12_limit_rd;
	logic [7:0] e11_duty_rd;
	logic [7:0] e12_duty_rd;
	logic [9:0] e11_thresh;
	logic [9:0] e12_thresh;
	logic [9:0] temp_cmp;
	logic       e11_hit;
	logic       e12_hit;
	logic [7:0] e11_duty_eff;
	logic [7:0] e12_duty_eff;
	logic       ext_active;
	logic       table_wr;

	assign req  = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
	assign mode = '{write_en:   ctrl_r[fan_table_pkg::CTRL_WRITE_EN_BIT],
	                temp_hires: ctrl_r[fan_table_pkg::CTRL_TEMP_HIRES],
	                duty_hires: ctrl_r[fan_table_pkg::CTRL_DUTY_HIRES],
	                freq_22k5:  ctrl_r[fan_table_pkg::CTRL_FREQ_22K5_BIT]};

	//////////////////////////////////////////////////////////////////////////////
	// register writes

	assign table_wr = req.wr && mode.write_en;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl_r <= fan_table_pkg::CTRL_RESET[3:0];
		end else if (req.wr && req.addr == fan_table_pkg::TABLE_CTRL_OFS) begin
			ctrl_r <= req.wdata[3:0];
		end
	end

	// the stored half bit and extension bits survive a mode change; only their use is masked
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			e11_limit_r <= fan_table_pkg::TEMP_LIMIT_RESET;
			e11_duty_r  <= fan_table_pkg::DUTY_RESET;
			e12_limit_r <= fan_table_pkg::TEMP_LIMIT_RESET;
			e12_duty_r  <= fan_table_pkg::DUTY_RESET;
		end else if (table_wr) begin
			case (req.addr)
				fan_table_pkg::ENTRY11_TEMP_LIMIT_OFS: e11_limit_r <= req.wdata;
				fan_table_pkg::ENTRY11_DUTY_OFS:       e11_duty_r  <= req.wdata;
				fan_table_pkg::ENTRY12_TEMP_LIMIT_OFS: e12_limit_r <= req.wdata;
				fan_table_pkg::ENTRY12_DUTY_OFS:       e12_duty_r  <= req.wdata;
				default: ;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// read view: unused bits show zero per mode

	assign e11_limit_rd = mode.temp_hires ? e11_limit_r : {1'b0, e11_limit_r[fan_table_pkg::LIMIT_WHOLE_HI:0]};
	assign e12_limit_rd = mode.temp_hires ? e12_limit_r : {1'b0, e12_limit_r[fan_table_pkg::LIMIT_WHOLE_HI:0]};
	assign e11_duty_rd  = mode.duty_hires ? e11_duty_r : {2'b00, e11_duty_r[fan_table_pkg::DUTY_BASE_HI:0]};
	assign e12_duty_rd  = mode.duty_hires ? e12_duty_r : {2'b00, e12_duty_r[fan_table_pkg::DUTY_BASE_HI:0]};

	always_comb begin
		case (req.addr)
			fan_table_pkg::ENTRY11_TEMP_LIMIT_OFS: rdata_nxt = e11_limit_rd;
			fan_table_pkg::ENTRY11_DUTY_OFS:       rdata_nxt = e11_duty_rd;
			fan_table_pkg::ENTRY12_TEMP_LIMIT_OFS: rdata_nxt = e12_limit_rd;
			fan_table_pkg::ENTRY12_DUTY_OFS:       rdata_nxt = e12_duty_rd;
			fan_table_pkg::TABLE_CTRL_OFS:         rdata_nxt = {4'h0, ctrl_r};
			fan_table_pkg::TABLE_STATUS_OFS:       rdata_nxt = {6'h00, e12_hit, e11_hit};
			default:                               rdata_nxt = fan_table_pkg::UNMAPPED_READ;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata <= 8'h00;
		end else if (req.rd) begin
			rdata <= rdata_nxt;
		end else begin
			rdata <= 8'h00;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// comparison, in half degrees, ten bits to hold limit plus offset

	// limit sign is never stored: bit 7 is the half bit, so the value is always positive
	assign e11_thresh = mode.temp_hires
		? {2'b00, e11_limit_r[fan_table_pkg::LIMIT_WHOLE_HI:0], e11_limit_r[fan_table_pkg::LIMIT_HALF_BIT]}
		  + {1'b0, table_temp_offset, 1'b0}
		: {2'b00, e11_limit_r[fan_table_pkg::LIMIT_WHOLE_HI:0], 1'b0}
		  + {1'b0, table_temp_offset, 1'b0};
	assign e12_thresh = mode.temp_hires
		? {2'b00, e12_limit_r[fan_table_pkg::LIMIT_WHOLE_HI:0], e12_limit_r[fan_table_pkg::LIMIT_HALF_BIT]}
		  + {1'b0, table_temp_offset, 1'b0}
		: {2'b00, e12_limit_r[fan_table_pkg::LIMIT_WHOLE_HI:0], 1'b0}
		  + {1'b0, table_temp_offset, 1'b0};

	// low resolution drops the half bit so a reading half a degree over does not trip
	assign temp_cmp = mode.temp_hires ? {1'b0, remote_temp} : {1'b0, remote_temp[8:1], 1'b0};

	assign e11_hit = temp_cmp > e11_thresh;
	assign e12_hit = temp_cmp > e12_thresh;

	//////////////////////////////////////////////////////////////////////////////
	// duty selection

	assign ext_active = mode.duty_hires && mode.freq_22k5;
	assign e11_duty_eff = ext_active ? e11_duty_r : {2'b00, e11_duty_r[fan_table_pkg::DUTY_BASE_HI:0]};
	assign e12_duty_eff = ext_active ? e12_duty_r : {2'b00, e12_duty_r[fan_table_pkg::DUTY_BASE_HI:0]};

	// the higher entry wins when both limits are exceeded
	always_comb begin
		if (e12_hit) begin
			duty_nxt  = e12_duty_eff;
			valid_nxt = 1'b1;
		end else if (e11_hit) begin
			duty_nxt  = e11_duty_eff;
			valid_nxt = 1'b1;
		end else begin
			duty_nxt  = 8'h00;
			valid_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			duty_out   <= 8'h00;
			duty_valid <= 1'b0;
		end else begin
			duty_out   <= duty_nxt;
			duty_valid <= valid_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// checks

	a_lowres_limit_read: assert property (@(posedge clk) disable iff (reset)
		rd && !mode.temp_hires && (addr == fan_table_pkg::ENTRY11_TEMP_LIMIT_OFS
		|| addr == fan_table_pkg::ENTRY12_TEMP_LIMIT_OFS) |=> rdata[7] == 1'b0)
		else $error("low resolution limit read shows top bit");

	a_lowres_duty_read: assert property (@(posedge clk) disable iff (reset)
		rd && !mode.duty_hires && (addr == fan_table_pkg::ENTRY11_DUTY_OFS
		|| addr == fan_table_pkg::ENTRY12_DUTY_OFS) |=> rdata[7:6] == 2'b00)
		else $error("low resolution duty read shows upper bits");

	a_write_blocked: assert property (@(posedge clk) disable iff (reset)
		wr && !mode.write_en |=> $stable(e11_limit_r) && $stable(e11_duty_r)
		&& $stable(e12_limit_r) && $stable(e12_duty_r))
		else $error("table entry changed while writes disabled");

	a_write_taken: assert property (@(posedge clk) disable iff (reset)
		wr && mode.write_en && addr == fan_table_pkg::ENTRY11_DUTY_OFS |=> e11_duty_r == $past(wdata))
		else $error("enabled write to entry 11 duty lost");

	a_e11_duty_out: assert property (@(posedge clk) disable iff (reset)
		e11_hit && !e12_hit ##1 $stable(e11_duty_r) |-> duty_valid && duty_out[5:0] == e11_duty_r[5:0])
		else $error("entry 11 duty not driven");

	a_e12_duty_out: assert property (@(posedge clk) disable iff (reset)
		e12_hit |=> duty_valid && duty_out[5:0] == $past(e12_duty_r[5:0]))
		else $error("entry 12 duty not driven");

	a_ext_gated: assert property (@(posedge clk) disable iff (reset)
		!(mode.duty_hires && mode.freq_22k5) |=> duty_out[7:6] == 2'b00)
		else $error("extended duty bits active without 22.5 kHz");

	a_lowres_compare: assert property (@(posedge clk) disable iff (reset)
		!mode.temp_hires && table_temp_offset == 8'h00
		&& remote_temp[8:1] == {1'b0, e11_limit_r[6:0]} |-> !e11_hit)
		else $error("low resolution compare uses half bit");

	a_no_hit_idle: assert property (@(posedge clk) disable iff (reset)
		!e11_hit && !e12_hit |=> !duty_valid && duty_out == 8'h00)
		else $error("duty driven with no limit exceeded");

	//////////////////////////////////////////////////////////////////////////////
	// reset checks: no disable here, the release edge itself is what is watched

	a_reset_values: assert property (@(posedge clk)
		$fell(reset) |-> e11_limit_r == fan_table_pkg::TEMP_LIMIT_RESET
		&& e11_duty_r == fan_table_pkg::DUTY_RESET && e12_limit_r == fan_table_pkg::TEMP_LIMIT_RESET
		&& e12_duty_r == fan_table_pkg::DUTY_RESET)
		else $error("table entries not at reset values after reset");

	a_reset_outputs: assert property (@(posedge clk)
		$fell(reset) |-> rdata == 8'h00 && duty_out == 8'h00 && !duty_valid)
		else $error("outputs not idle after reset");

	//////////////////////////////////////////////////////////////////////////////
	// register port checks

	a_e11_limit_taken: assert property (@(posedge clk) disable iff (reset)
		wr && mode.write_en && addr == fan_table_pkg::ENTRY11_TEMP_LIMIT_OFS |=> e11_limit_r == $past(wdata))
		else $error("enabled write to entry 11 limit lost");

	a_e12_limit_taken: assert property (@(posedge clk) disable iff (reset)
		wr && mode.write_en && addr == fan_table_pkg::ENTRY12_TEMP_LIMIT_OFS |=> e12_limit_r == $past(wdata))
		else $error("enabled write to entry 12 limit lost");

	a_e12_duty_taken: assert property (@(posedge clk) disable iff (reset)
		wr && mode.write_en && addr == fan_table_pkg::ENTRY12_DUTY_OFS |=> e12_duty_r == $past(wdata))
		else $error("enabled write to entry 12 duty lost");

	// the control register stays writable so that the write enable can be lifted
	a_ctrl_write: assert property (@(posedge clk) disable iff (reset)
		wr && addr == fan_table_pkg::TABLE_CTRL_OFS |=> ctrl_r == $past(wdata[3:0]))
		else $error("control write lost");

	a_e11_limit_view: assert property (@(posedge clk) disable iff (reset)
		rd && mode.temp_hires && addr == fan_table_pkg::ENTRY11_TEMP_LIMIT_OFS |=> rdata == $past(e11_limit_r))
		else $error("high resolution entry 11 limit read wrong");

	a_e12_limit_view: assert property (@(posedge clk) disable iff (reset)
		rd && mode.temp_hires && addr == fan_table_pkg::ENTRY12_TEMP_LIMIT_OFS |=> rdata == $past(e12_limit_r))
		else $error("high resolution entry 12 limit read wrong");

	a_e11_duty_view: assert property (@(posedge clk) disable iff (reset)
		rd && mode.duty_hires && addr == fan_table_pkg::ENTRY11_DUTY_OFS |=> rdata == $past(e11_duty_r))
		else $error("high resolution entry 11 duty read wrong");

	a_e12_duty_view: assert property (@(posedge clk) disable iff (reset)
		rd && mode.duty_hires && addr == fan_table_pkg::ENTRY12_DUTY_OFS |=> rdata == $past(e12_duty_r))
		else $error("high resolution entry 12 duty read wrong");

	a_limit_low_bits: assert property (@(posedge clk) disable iff (reset)
		rd && !mode.temp_hires && addr == fan_table_pkg::ENTRY12_TEMP_LIMIT_OFS
		|=> rdata[6:0] == $past(e12_limit_r[6:0]))
		else $error("low resolution limit read loses whole degrees");

	a_duty_base_read: assert property (@(posedge clk) disable iff (reset)
		rd && !mode.duty_hires && addr == fan_table_pkg::ENTRY11_DUTY_OFS
		|=> rdata[5:0] == $past(e11_duty_r[5:0]))
		else $error("low resolution duty read loses base bits");

	a_ctrl_read: assert property (@(posedge clk) disable iff (reset)
		rd && addr == fan_table_pkg::TABLE_CTRL_OFS |=> rdata == {4'h0, $past(ctrl_r)})
		else $error("control read wrong");

	a_status_read: assert property (@(posedge clk) disable iff (reset)
		rd && addr == fan_table_pkg::TABLE_STATUS_OFS |=> rdata == {6'h00, $past(e12_hit), $past(e11_hit)})
		else $error("status read wrong");

	a_unmapped_read: assert property (@(posedge clk) disable iff (reset)
		rd && (addr < fan_table_pkg::ENTRY11_TEMP_LIMIT_OFS || addr > fan_table_pkg::TABLE_STATUS_OFS)
		|=> rdata == fan_table_pkg::UNMAPPED_READ)
		else $error("unmapped read not zero");

	a_rdata_idle: assert property (@(posedge clk) disable iff (reset)
		!rd |=> rdata == 8'h00)
		else $error("read data outside the read cycle");

	//////////////////////////////////////////////////////////////////////////////
	// comparison checks

	// at or below the offset no stored limit can be exceeded, whatever the mode
	a_offset_floor: assert property (@(posedge clk) disable iff (reset)
		{1'b0, remote_temp} <= {1'b0, table_temp_offset, 1'b0} |-> !e11_hit && !e12_hit)
		else $error("limit exceeded below the table offset");

	// above 255 half degrees every direct limit is passed when no offset applies
	a_limit_ceiling: assert property (@(posedge clk) disable iff (reset)
		table_temp_offset == 8'h00 && remote_temp > 9'h0ff |-> e11_hit && e12_hit)
		else $error("limit above the direct range");

	a_half_step: assert property (@(posedge clk) disable iff (reset)
		mode.temp_hires && table_temp_offset == 8'h00 && remote_temp == {1'b0,
		e12_limit_r[fan_table_pkg::LIMIT_WHOLE_HI:0], e12_limit_r[fan_table_pkg::LIMIT_HALF_BIT]} + 9'h001 |-> e12_hit)
		else $error("half degree over the limit not seen");

	//////////////////////////////////////////////////////////////////////////////
	// duty checks

	a_base_duty_sel: assert property (@(posedge clk) disable iff (reset)
		!(mode.duty_hires && mode.freq_22k5) && e12_hit
		|=> duty_out == {2'b00, $past(e12_duty_r[fan_table_pkg::DUTY_BASE_HI:0])})
		else $error("low resolution duty not taken from base bits");

	a_ext_duty_e12: assert property (@(posedge clk) disable iff (reset)
		mode.duty_hires && mode.freq_22k5 && e12_hit |=> duty_out == $past(e12_duty_r))
		else $error("entry 12 extended duty not driven");

	a_ext_duty_e11: assert property (@(posedge clk) disable iff (reset)
		mode.duty_hires && mode.freq_22k5 && e11_hit && !e12_hit |=> duty_out == $past(e11_duty_r))
		else $error("entry 11 extended duty not driven");

	a_hit_valid: assert property (@(posedge clk) disable iff (reset)
		e11_hit || e12_hit |=> duty_valid)
		else $error("duty not flagged valid over a limit");

endmodule

// >>> remote_diode_model.sv
// partner model: remote diode temperature and table offset seen by the fan table
module remote_diode_model (
	// clock
	input  wire logic       clk,
	// measured levels
	output logic      [8:0] remote_temp,
	output logic      [7:0] table_temp_offset
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		remote_temp = 9'h000;
		table_temp_offset = 8'h00;
	end

	////////////////////////////////////////
	// levels move only just after an edge, so the table never samples a moving reading
	task automatic apply(input logic [8:0] t, input logic [7:0] o);
		@(posedge clk);
		remote_temp <= t;
		table_temp_offset <= o;
	endtask
endmodule

// >>> testbench.sv
// testbench: fan table entries 11 and 12 against a behavioural model
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clk, reset, wr, rd, duty_valid;
	logic [7:0] addr, wdata, rdata, duty_out, table_temp_offset;
	logic [8:0] remote_temp;
	int         error_cnt = 0;
	int         num_checks = 0;
	int         seed = 70;
	int         lim[2], dty[2], ctrl, t, o, mode, k;

	fan_lut_upper_entries fan_lut_upper_entries_i (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .remote_temp(remote_temp), .table_temp_offset(table_temp_offset),
		.duty_out(duty_out), .duty_valid(duty_valid));
	remote_diode_model remote_diode_model_i (.clk(clk), .remote_temp(remote_temp),
		.table_temp_offset(table_temp_offset));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	////////////////////////////////////////
	task automatic finish_test;
		if (error_cnt == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic cmp_val(input logic [8:0] got, input logic [8:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_duty(input logic [7:0] got_duty, input logic got_valid,
		input logic [7:0] exp_duty, input logic exp_valid);
		num_checks++;
		if (got_duty !== exp_duty || got_valid !== exp_valid) begin
			error_cnt++;
			$display("Error at %0t: duty %h valid %b expected %h %b", $time, got_duty, got_valid, exp_duty, exp_valid);
		end
	endtask

	// model of what software sees when reading an address
	function automatic int view(int a);
		if (a == 8'h68)
			return ctrl & 8'h0f;
		if (a == 8'h69)
			return hit(1) * 2 + hit(0);
		if (a < 8'h64 || a > 8'h67)
			return 0;
		if (a % 2 == 0)
			return ctrl[1] ? lim[(a - 8'h64) / 2] : lim[(a - 8'h64) / 2] & 8'h7f;
		return ctrl[2] ? dty[(a - 8'h64) / 2] : dty[(a - 8'h64) / 2] & 8'h3f;
	endfunction

	// threshold in half degrees, offset in whole degrees
	function automatic int thr(int i);
		return (lim[i] & 8'h7f) * 2 + (ctrl[1] ? lim[i] >> 7 : 0) + 2 * o;
	endfunction

	function automatic int hit(int i);
		return (ctrl[1] ? t : t & 9'h1fe) > thr(i);
	endfunction

	////////////////////////////////////////
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		if (a == 8'h68)
			ctrl = d;
		else if (ctrl[0] && a >= 8'h64 && a <= 8'h67 && !a[0])
			lim[(a - 8'h64) >> 1] = d;
		else if (ctrl[0] && a >= 8'h64 && a <= 8'h67)
			dty[(a - 8'h64) >> 1] = d;
	endtask

	task automatic rd_check(input logic [7:0] a, input int exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		cmp_val({1'b0, rdata}, 9'(exp));
	endtask

	// entry 12 wins when both limits are exceeded
	task automatic duty_check;
		int d;
		d = hit(1) ? dty[1] : hit(0) ? dty[0] : 0;
		if (!(ctrl[2] && ctrl[3]))
			d = d & 8'h3f;
		remote_diode_model_i.apply(9'(t), 8'(o));
		@(posedge clk);
		#1;
		cmp_duty(duty_out, duty_valid, d[7:0], 1'(hit(0) | hit(1)));
	endtask

	////////////////////////////////////////
	initial begin
		reset = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		ctrl = 0;
		lim = '{8'h7f, 8'h7f};
		dty = '{8'h3f, 8'h3f};
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		for (k = 8'h64; k <= 8'h67; k++) rd_check(8'(k), view(k));
		wr_reg(8'h65, 8'h15);
		rd_check(8'h65, view(8'h65));
		rd_check(8'h70, 0);
		for (mode = 0; mode < 8; mode++) begin
			wr_reg(8'h68, 8'(8'hf0 | mode * 2 + 1));
			rd_check(8'h68, view(8'h68));
			for (k = 0; k < 4; k++) wr_reg(8'(8'h64 + k), 8'($random(seed)));
			for (k = 8'h64; k <= 8'h67; k++) rd_check(8'(k), view(k));
			for (k = 0; k < 12; k++) begin
				// with no offset, the first three steps sit on the entry 11 limit, half a degree over the entry 12 limit and above the direct range
				o = (k < 3) ? 0 : $random(seed) & 8'h1f;
				t = (k == 0) ? thr(0) : (k == 1) ? thr(1) + 1 : $random(seed);
				if (k == 2)
					t = t | 9'h100;
				t = t & 9'h1ff;
				duty_check;
				rd_check(8'h69, view(8'h69));
			end
		end
		// writes with the enable cleared must leave every entry as it was
		wr_reg(8'h68, 8'h06);
		for (k = 0; k < 4; k++) wr_reg(8'(8'h64 + k), 8'($random(seed)));
		for (k = 8'h64; k <= 8'h67; k++) rd_check(8'(k), view(k));
		// a reset in mid-run must bring back the power-on values
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		ctrl = 0;
		lim = '{8'h7f, 8'h7f};
		dty = '{8'h3f, 8'h3f};
		for (k = 8'h64; k <= 8'h68; k++) rd_check(8'(k), view(k));
		finish_test;
	end

	// the sequence needs a few thousand ns; this leaves a wide margin
	initial begin
		#20000;
		error_cnt++;
		finish_test;
	end
endmodule
